// ==== design/cect_core.sv ====
// Overview of operation
// - Test each instruction's condition against the flags
// - Single-flag and unsigned comparisons decode as listed
// - Signed at-least and below compare sign, overflow
// - Signed above and at-most also use zero
// - Default always runs, never condition never runs
// - Failed condition skips, costs one sequential cycle
// - Flags load when forced or update permitted
// - Next-word access is sequential, long over quads; the core only raises cyc_quad_cross_o, no extra cycle
// - Unrelated addresses use non-sequential cycles
// - No memory or coprocessor need means internal
// - Coprocessor moves and data op cycle counts
// - Data processing one S, plus shift, pc extras
// - Word load 1S+1N+1I, store two N
// - Multi load nS+1N+1I, pc adds S+N
// - Multi store (n-1)S plus two N
// - Product 1S plus operand-dependent internal cycles
// - Coprocessor load/store (n-1)S plus two N
// - Busy coprocessor stretches coprocessor instructions
`timescale 1ns/1ns
`default_nettype none
module cect_core
  import cect_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  input wire logic [3:0] instr_cond_i,
  input wire logic [3:0] instr_class_i,
  input wire logic [31:0] instr_pc_i,
  input wire logic [4:0] instr_count_i,
  input wire logic [31:0] instr_operand_i,
  input wire logic instr_pc_dest_i,
  input wire logic instr_reg_shift_i,
  input wire logic instr_set_flags_i,
  input wire logic instr_force_flags_i,
  input wire logic [3:0] alu_flags_i,
  input wire logic cp_busy_i,
  output logic cyc_valid_o,
  output logic [1:0] cyc_type_o,
  output logic [29:0] cyc_addr_o,
  output logic cyc_quad_cross_o,
  output logic instr_done_o,
  output logic [3:0] flags_o
);

  cect_phase_t phase_reg;
  cect_phase_t phase_next;
  logic [4:0] s_cnt_reg, n_cnt_reg, i_cnt_reg, c_cnt_reg;
  logic [4:0] s_dec, n_dec, i_dec, c_dec;
  logic [4:0] ld_s, ld_n, ld_i, ld_c;
  logic [4:0] prod_i;
  logic [4:0] multi_n;
  logic [3:0] flags_reg;
  logic [3:0] alu_flags_reg;
  logic upd_reg, exec_reg, step_reg, enable_reg, done_reg;
  logic [29:0] addr_reg;
  logic [31:0] exec_cnt_reg, skip_cnt_reg, cycle_cnt_reg;
  logic cond_pass, accept, issuing, last_cycle, is_cop;
  logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic do_write, flag_wr;

  cect_cond_eval u_cond (
    .cond_i(instr_cond_i),
    .flags_i(flags_reg),
    .pass_o(cond_pass)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // First phase, in S, N, I, C order, with cycles still owed
  function automatic cect_phase_t pick(input logic [4:0] s, input logic [4:0] n,
                                       input logic [4:0] i, input logic [4:0] c);
    if (s != 5'h00) return PH_S;
    else if (n != 5'h00) return PH_N;
    else if (i != 5'h00) return PH_I;
    else if (c != 5'h00) return PH_C;
    else return PH_IDLE;
  endfunction : pick

  assign instr_ready_o = enable_reg && (phase_reg == PH_IDLE);
  assign accept = instr_valid_i && instr_ready_o;
  assign is_cop = (instr_class_i == CLS_COPROC_DATA_OP) || (instr_class_i == CLS_COPROC_LOAD_STORE)
                  || (instr_class_i == CLS_COPROC_TO_CORE_MOVE)
                  || (instr_class_i == CLS_CORE_TO_COPROC_MOVE);
  assign multi_n = (instr_count_i == 5'h00) ? 5'h01 : instr_count_i;

  // Internal cycles grow by one per two bits of operand magnitude
  always_comb begin
    prod_i = 5'h01;
    for (int b = 1; b < 32; b++) begin
      if (instr_operand_i[b]) begin
        prod_i = 5'((b + 1) / 2 + 1);
      end
    end
    if (prod_i > PRODUCT_MAX_I) begin
      prod_i = PRODUCT_MAX_I;
    end
  end

  always_comb begin
    ld_s = 5'h00;
    ld_n = 5'h00;
    ld_i = 5'h00;
    ld_c = 5'h00;
    if (!cond_pass) begin
      ld_s = 5'h01;
    end else begin
      case (instr_class_i)
        CLS_DATA_PROC: begin
          ld_s = 5'h01 + {4'h0, instr_reg_shift_i} + {4'h0, instr_pc_dest_i};
          ld_n = {4'h0, instr_pc_dest_i};
        end
        CLS_WORD_LOAD: begin
          ld_s = 5'h01 + {4'h0, instr_pc_dest_i};
          ld_n = 5'h01 + {4'h0, instr_pc_dest_i};
          ld_i = 5'h01;
        end
        CLS_WORD_STORE: ld_n = 5'h02;
        CLS_MULTI_LOAD: begin
          ld_s = multi_n + {4'h0, instr_pc_dest_i};
          ld_n = 5'h01 + {4'h0, instr_pc_dest_i};
          ld_i = 5'h01;
        end
        CLS_MULTI_STORE: begin
          ld_s = multi_n - 5'h01;
          ld_n = 5'h02;
        end
        CLS_PRODUCT: begin
          ld_s = 5'h01;
          ld_i = prod_i;
        end
        CLS_COPROC_DATA_OP: ld_s = 5'h01;
        CLS_COPROC_LOAD_STORE: begin
          ld_s = multi_n - 5'h01;
          ld_n = 5'h02;
        end
        CLS_COPROC_TO_CORE_MOVE: begin
          ld_s = 5'h01;
          ld_c = 5'h01;
        end
        CLS_CORE_TO_COPROC_MOVE: begin
          ld_s = 5'h01;
          ld_i = 5'h01;
          ld_c = 5'h01;
        end
        default: begin
          ld_s = 5'h02;
          ld_n = 5'h01;
        end
      endcase
    end
  end

  assign issuing = (phase_reg == PH_S) || (phase_reg == PH_N) || (phase_reg == PH_I)
                   || (phase_reg == PH_C);

  always_comb begin
    s_dec = s_cnt_reg;
    n_dec = n_cnt_reg;
    i_dec = i_cnt_reg;
    c_dec = c_cnt_reg;
    case (phase_reg)
      PH_S: s_dec = s_cnt_reg - 5'h01;
      PH_N: n_dec = n_cnt_reg - 5'h01;
      PH_I: i_dec = i_cnt_reg - 5'h01;
      PH_C: c_dec = c_cnt_reg - 5'h01;
      default: s_dec = s_cnt_reg;
    endcase
  end

  assign last_cycle = issuing && (pick(s_dec, n_dec, i_dec, c_dec) == PH_IDLE);

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_IDLE: begin
        if (accept) begin
          // A skipped coprocessor instruction never talks to the coprocessor
          phase_next = (is_cop && cond_pass) ? PH_WAIT : pick(ld_s, ld_n, ld_i, ld_c);
        end
      end
      PH_WAIT: begin
        if (!cp_busy_i) begin
          phase_next = pick(s_cnt_reg, n_cnt_reg, i_cnt_reg, c_cnt_reg);
        end
      end
      PH_S, PH_N, PH_I, PH_C: phase_next = pick(s_dec, n_dec, i_dec, c_dec);
      default: phase_next = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_reg <= PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_cnt_reg <= 5'h00;
      n_cnt_reg <= 5'h00;
      i_cnt_reg <= 5'h00;
      c_cnt_reg <= 5'h00;
    end else if (accept) begin
      s_cnt_reg <= ld_s;
      n_cnt_reg <= ld_n;
      i_cnt_reg <= ld_i;
      c_cnt_reg <= ld_c;
    end else if (issuing) begin
      s_cnt_reg <= s_dec;
      n_cnt_reg <= n_dec;
      i_cnt_reg <= i_dec;
      c_cnt_reg <= c_dec;
    end
  end

  // Busy coprocessor time shows as internal cycles on the cycle port
  assign cyc_valid_o = issuing || ((phase_reg == PH_WAIT) && cp_busy_i);
  always_comb begin
    case (phase_reg)
      PH_S: cyc_type_o = CYC_S;
      PH_N: cyc_type_o = CYC_N;
      PH_C: cyc_type_o = CYC_C;
      default: cyc_type_o = CYC_I;
    endcase
  end
  assign cyc_addr_o = addr_reg;
  assign cyc_quad_cross_o = (phase_reg == PH_S) && step_reg && (addr_reg[1:0] == 2'h0);

  // Sequential cycles walk word by word from the instruction address
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      addr_reg <= 30'h0;
      step_reg <= 1'b0;
    end else if (accept) begin
      addr_reg <= instr_pc_i[31:2];
      step_reg <= 1'b0;
    end else if (phase_reg == PH_S) begin
      addr_reg <= addr_reg + 30'h1;
      step_reg <= 1'b1;
    end else if (issuing) begin
      step_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      upd_reg <= 1'b0;
      exec_reg <= 1'b0;
      alu_flags_reg <= FLAGS_RESET;
    end else if (accept) begin
      upd_reg <= cond_pass && (instr_force_flags_i || instr_set_flags_i);
      exec_reg <= cond_pass;
      alu_flags_reg <= alu_flags_i;
    end
  end

  assign flag_wr = do_write && (awaddr_reg == REG_FLAGS) && wstrb_reg[0];

  // Result flags from the instruction win over a software write
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flags_reg <= FLAGS_RESET;
    end else if (last_cycle && upd_reg) begin
      flags_reg <= alu_flags_reg;
    end else if (flag_wr) begin
      flags_reg <= wdata_reg[3:0];
    end
  end
  assign flags_o = flags_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      done_reg <= 1'b0;
      exec_cnt_reg <= 32'h0;
      skip_cnt_reg <= 32'h0;
      cycle_cnt_reg <= 32'h0;
    end else begin
      done_reg <= last_cycle;
      if (last_cycle && exec_reg) begin
        exec_cnt_reg <= exec_cnt_reg + 32'h1;
      end
      if (last_cycle && !exec_reg) begin
        skip_cnt_reg <= skip_cnt_reg + 32'h1;
      end
      if (cyc_valid_o) begin
        cycle_cnt_reg <= cycle_cnt_reg + 32'h1;
      end
    end
  end
  assign instr_done_o = done_reg;

  // Register slave: one write and one read in flight, address and data in any order
  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = !w_got_reg && !bvalid_reg;
  assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= ((awaddr_reg == REG_CTRL) || (awaddr_reg == REG_FLAGS))
                     ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      enable_reg <= CTRL_RESET;
    end else if (do_write && (awaddr_reg == REG_CTRL) && wstrb_reg[0]) begin
      enable_reg <= wdata_reg[0];
    end
  end

  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: rdata_reg <= {31'h0, enable_reg};
        REG_FLAGS: rdata_reg <= {28'h0, flags_reg};
        REG_STATUS: rdata_reg <= {26'h0, exec_reg, (phase_reg == PH_WAIT), phase_reg, issuing};
        REG_EXEC_CNT: rdata_reg <= exec_cnt_reg;
        REG_SKIP_CNT: rdata_reg <= skip_cnt_reg;
        REG_CYCLE_CNT: rdata_reg <= cycle_cnt_reg;
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  sequence s_cyc(logic [1:0] t);
    cyc_valid_o && (cyc_type_o == t);
  endsequence

  sequence s_back_idle;
    (phase_reg == PH_IDLE);
  endsequence

  skip_one_seq_a: assert property (accept && !cond_pass
      |=> s_cyc(CYC_S) ##1 s_back_idle)
    else $error("skipped instruction did not cost one S cycle");
  never_blocks_a: assert property (accept && (instr_cond_i == NEVER_COND) |-> !cond_pass)
    else $error("never condition passed");
  always_runs_a: assert property (accept && (instr_cond_i == EVERY_TIME_COND) |-> cond_pass)
    else $error("always condition failed");
  branch_timing_a: assert property (accept && cond_pass && (instr_class_i == CLS_BRANCH)
      |=> s_cyc(CYC_S) ##1 s_cyc(CYC_S) ##1 s_cyc(CYC_N) ##1 s_back_idle)
    else $error("branch did not take 2S+1N");
  store_timing_a: assert property (accept && cond_pass && (instr_class_i == CLS_WORD_STORE)
      |=> s_cyc(CYC_N) [*2] ##1 s_back_idle)
    else $error("word store did not take 2N");
  product_small_a: assert property (accept && cond_pass && (instr_class_i == CLS_PRODUCT)
      && (instr_operand_i[31:1] == 31'h0)
      |=> s_cyc(CYC_S) ##1 s_cyc(CYC_I) ##1 s_back_idle)
    else $error("small product did not take 1S+1I");
  busy_stretch_a: assert property ((phase_reg == PH_WAIT) && cp_busy_i
      |-> s_cyc(CYC_I) ##1 (phase_reg == PH_WAIT))
    else $error("busy coprocessor did not hold the instruction");
  flags_update_a: assert property (last_cycle && upd_reg |=> flags_reg == $past(alu_flags_reg))
    else $error("result flags not loaded");
  flags_kept_a: assert property (last_cycle && !upd_reg && !flag_wr |=> $stable(flags_reg))
    else $error("flags changed without permission");
  quad_cross_a: assert property (cyc_quad_cross_o |-> $past(phase_reg) == PH_S
      && ($past(addr_reg[1:0]) == 2'h3))
    else $error("quad crossing flagged off a boundary");

endmodule : cect_core
`default_nettype wire

// ==== design/cect_pkg.sv ====
package cect_pkg;

  // Condition codes carried in the top nibble of every instruction
  localparam logic [3:0] ZERO_SET_COND = 4'h0;
  localparam logic [3:0] ZERO_CLEAR_COND = 4'h1;
  localparam logic [3:0] CARRY_SET_COND = 4'h2;
  localparam logic [3:0] CARRY_CLEAR_COND = 4'h3;
  localparam logic [3:0] SIGN_SET_COND = 4'h4;
  localparam logic [3:0] SIGN_CLEAR_COND = 4'h5;
  localparam logic [3:0] OVF_SET_COND = 4'h6;
  localparam logic [3:0] OVF_CLEAR_COND = 4'h7;
  localparam logic [3:0] UNSIGNED_ABOVE_COND = 4'h8;
  localparam logic [3:0] UNSIGNED_NOT_ABOVE_COND = 4'h9;
  localparam logic [3:0] SIGNED_AT_LEAST_COND = 4'ha;
  localparam logic [3:0] SIGNED_BELOW_COND = 4'hb;
  localparam logic [3:0] SIGNED_ABOVE_COND = 4'hc;
  localparam logic [3:0] SIGNED_AT_MOST_COND = 4'hd;
  localparam logic [3:0] EVERY_TIME_COND = 4'he;
  localparam logic [3:0] NEVER_COND = 4'hf;
  // Source-side aliases share the carry encodings
  localparam logic [3:0] CARRY_SET_ALIAS = CARRY_SET_COND;
  localparam logic [3:0] CARRY_CLEAR_ALIAS = CARRY_CLEAR_COND;

  // Flag bit positions within the status nibble
  localparam int FLAG_V = 0;
  localparam int FLAG_C = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;

  // Instruction classes
  localparam logic [3:0] CLS_DATA_PROC = 4'h0;
  localparam logic [3:0] CLS_WORD_LOAD = 4'h1;
  localparam logic [3:0] CLS_WORD_STORE = 4'h2;
  localparam logic [3:0] CLS_MULTI_LOAD = 4'h3;
  localparam logic [3:0] CLS_MULTI_STORE = 4'h4;
  localparam logic [3:0] CLS_BRANCH = 4'h5;
  localparam logic [3:0] CLS_PRODUCT = 4'h6;
  localparam logic [3:0] CLS_COPROC_DATA_OP = 4'h7;
  localparam logic [3:0] CLS_COPROC_LOAD_STORE = 4'h8;
  localparam logic [3:0] CLS_COPROC_TO_CORE_MOVE = 4'h9;
  localparam logic [3:0] CLS_CORE_TO_COPROC_MOVE = 4'ha;

  // Cycle type codes on the cycle port
  localparam logic [1:0] CYC_S = 2'h0;
  localparam logic [1:0] CYC_N = 2'h1;
  localparam logic [1:0] CYC_I = 2'h2;
  localparam logic [1:0] CYC_C = 2'h3;

  localparam logic [4:0] PRODUCT_MAX_I = 5'h10;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_EXEC_CNT = 8'h0c;
  localparam logic [7:0] REG_SKIP_CNT = 8'h10;
  localparam logic [7:0] REG_CYCLE_CNT = 8'h14;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic CTRL_RESET = 1'b0;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // Gray codes along the usual path wait, S, N, I, C
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_WAIT = 3'b001,
    PH_S = 3'b011,
    PH_N = 3'b010,
    PH_I = 3'b110,
    PH_C = 3'b111
  } cect_phase_t;

endpackage : cect_pkg

// ==== design/cect_cond_eval.sv ====
`timescale 1ns/1ns
`default_nettype none
module cect_cond_eval
  import cect_pkg::*;
(
  input wire logic [3:0] cond_i,
  input wire logic [3:0] flags_i,
  output logic pass_o
);

  logic n;
  logic z;
  logic c;
  logic v;

  assign n = flags_i[FLAG_N];
  assign z = flags_i[FLAG_Z];
  assign c = flags_i[FLAG_C];
  assign v = flags_i[FLAG_V];

  always_comb begin
    case (cond_i)
      ZERO_SET_COND: pass_o = z;
      ZERO_CLEAR_COND: pass_o = !z;
      CARRY_SET_COND: pass_o = c;
      CARRY_CLEAR_COND: pass_o = !c;
      SIGN_SET_COND: pass_o = n;
      SIGN_CLEAR_COND: pass_o = !n;
      OVF_SET_COND: pass_o = v;
      OVF_CLEAR_COND: pass_o = !v;
      UNSIGNED_ABOVE_COND: pass_o = c && !z;
      UNSIGNED_NOT_ABOVE_COND: pass_o = !c || z;
      SIGNED_AT_LEAST_COND: pass_o = (n == v);
      SIGNED_BELOW_COND: pass_o = (n != v);
      SIGNED_ABOVE_COND: pass_o = (n == v) && !z;
      SIGNED_AT_MOST_COND: pass_o = (n != v) || z;
      EVERY_TIME_COND: pass_o = 1'b1;
      default: pass_o = 1'b0;
    endcase
  end

endmodule : cect_cond_eval
`default_nettype wire

// ==== verif/cect_cp_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cect_cp_model
  import cect_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic accept_i,
  input wire logic [3:0] busy_len_i,
  input wire logic cyc_valid_i,
  input wire logic [1:0] cyc_type_i,
  input wire logic quad_i,
  input wire logic done_i,
  output logic cp_busy_o,
  output logic [27:0] tally_o
);
  logic [3:0] busy_reg = 4'h0;
  // Busy is a commanded span from the accept edge, so waits can be long or none
  assign cp_busy_o = busy_reg != 4'h0;
  always @(posedge clk_i) begin
    if (srst_i) begin
      busy_reg <= 4'h0;
    end else if (accept_i) begin
      busy_reg <= busy_len_i;
    end else if (busy_reg != 4'h0) begin
      busy_reg <= busy_reg - 4'h1;
    end
  end
  // Tally of cycle kinds since the last done pulse, packed {quad, S, N, I, C}
  always @(posedge clk_i) begin
    if (srst_i || done_i) begin
      tally_o <= 28'h0;
    end else if (cyc_valid_i) begin
      tally_o[27:24] <= tally_o[27:24] + {3'h0, quad_i};
      case (cyc_type_i)
        CYC_S: tally_o[23:18] <= tally_o[23:18] + 6'h1;
        CYC_N: tally_o[17:12] <= tally_o[17:12] + 6'h1;
        CYC_I: tally_o[11:6] <= tally_o[11:6] + 6'h1;
        default: tally_o[5:0] <= tally_o[5:0] + 6'h1;
      endcase
    end
  end
endmodule : cect_cp_model
`default_nettype wire

// ==== verif/tb_cond_exec_cycle_timing.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_cond_exec_cycle_timing
  import cect_pkg::*;
;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic instr_valid_i = 1'b0, instr_pc_dest_i = 1'b0, instr_reg_shift_i = 1'b0;
  logic instr_set_flags_i = 1'b0, instr_force_flags_i = 1'b0;
  logic [3:0] instr_cond_i = 4'h0, instr_class_i = 4'h0, alu_flags_i = 4'h0, blen = 4'h0;
  logic [4:0] instr_count_i = 5'h0;
  logic [31:0] instr_pc_i = 32'h0, instr_operand_i = 32'h0;
  logic instr_ready_o, cyc_valid_o, cyc_quad_cross_o, instr_done_o, cp_busy_i;
  logic [1:0] cyc_type_o;
  logic [3:0] flags_o, f, a;
  logic [27:0] tally;
  logic [31:0] seed = 32'hc10b;
  logic [31:0] op, em;
  logic [31:0] expq[$];
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0, ncyc = 0;

  cect_core dut (.clk_i, .srst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .instr_valid_i, .instr_ready_o, .instr_cond_i, .instr_class_i, .instr_pc_i,
    .instr_count_i, .instr_operand_i, .instr_pc_dest_i, .instr_reg_shift_i, .instr_set_flags_i,
    .instr_force_flags_i, .alu_flags_i, .cp_busy_i, .cyc_valid_o, .cyc_type_o, .cyc_addr_o(),
    .cyc_quad_cross_o, .instr_done_o, .flags_o);

  cect_cp_model partner (.clk_i(clk_i), .srst_i(srst_i),
    .accept_i(instr_valid_i && instr_ready_o), .busy_len_i(blen), .cyc_valid_i(cyc_valid_o),
    .cyc_type_i(cyc_type_o), .quad_i(cyc_quad_cross_o), .done_i(instr_done_o),
    .cp_busy_o(cp_busy_i), .tally_o(tally));

  always #10 clk_i = ~clk_i;

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      results();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic pass(input logic [3:0] c, input logic [3:0] fl);
    logic n, z, cy, v;
    {n, z, cy, v} = fl;
    case (c)
      4'h0: return z;
      4'h1: return !z;
      4'h2: return cy;
      4'h3: return !cy;
      4'h4: return n;
      4'h5: return !n;
      4'h6: return v;
      4'h7: return !v;
      4'h8: return cy && !z;
      4'h9: return !cy || z;
      4'ha: return n == v;
      4'hb: return n != v;
      4'hc: return n == v && !z;
      4'hd: return n != v || z;
      4'he: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : pass

  function automatic int px(input logic [31:0] v);
    int x = 1;
    while (x < 16 && v >= (32'h1 << (2 * x - 1))) x++;
    return x;
  endfunction : px

  // Packed note {flags, quad, S, N, I, C}; quad 15 means not judged
  function automatic logic [31:0] ex(input int s, n, i, c, q, input logic [3:0] fl);
    return {fl, q[3:0], s[5:0], n[5:0], i[5:0], c[5:0]};
  endfunction : ex

  task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    logic pa = 1'b1, pw = 1'b1, pb = 1'b1;
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pb) begin
      @(negedge clk_i);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      if (s_axi_bvalid) begin
        pb = 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
      end
      @(posedge clk_i);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
      s_axi_bready <= pb;
    end
    @(posedge clk_i);
  endtask : axw

  task automatic axr(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
    logic pa = 1'b1, pr = 1'b1;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (pr) begin
      @(negedge clk_i);
      pa = pa && !s_axi_arready;
      if (s_axi_rvalid) begin
        pr = 1'b0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
      @(posedge clk_i);
      s_axi_arvalid <= pa;
      s_axi_rready <= pr;
    end
    @(posedge clk_i);
  endtask : axr

  // b is {pc written, register shift, update option, forced load}
  task automatic issue(input logic [3:0] c, input logic [3:0] k, input logic [4:0] n,
      input logic [31:0] v, input logic [31:0] pc, input logic [3:0] b, input logic [3:0] alu,
      input logic [3:0] bl, input logic [31:0] e);
    expq.push_back(e);
    instr_cond_i <= c;
    instr_class_i <= k;
    instr_count_i <= n;
    instr_operand_i <= v;
    instr_pc_i <= pc;
    {instr_pc_dest_i, instr_reg_shift_i, instr_set_flags_i, instr_force_flags_i} <= b;
    alu_flags_i <= alu;
    blen <= bl;
    instr_valid_i <= 1'b1;
    @(negedge clk_i);
    while (instr_ready_o !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    // Wait for idle so a following flags write cannot meet a hardware flag load
    do @(negedge clk_i); while (instr_ready_o !== 1'b1);
    @(posedge clk_i);
  endtask : issue

  always @(negedge clk_i) begin
    if (instr_done_o === 1'b1) begin
      if (expq.size() == 0) begin
        n_fail++;
        $display("[FAIL] %0t done without a pending instruction", $time);
      end else begin
        em = expq.pop_front();
        if (em[27:24] == 4'hf) em[27:24] = tally[27:24];
        ncyc += em[23:18] + em[17:12] + em[11:6] + em[5:0];
        chk({flags_o, tally}, em);
      end
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    axr(REG_CTRL, 32'h0, RESP_OKAY);
    axr(REG_FLAGS, 32'h0, RESP_OKAY);
    axw(REG_STATUS, 32'h1, RESP_SLVERR);
    axr(8'h40, 32'h0, RESP_SLVERR);
    axw(REG_CTRL, 32'h1, RESP_OKAY);
    axr(REG_CTRL, 32'h1, RESP_OKAY);
    $display("test registers done");
    for (int j = 0; j < 48; j++) begin
      seed = lfsr(seed);
      f = seed[3:0];
      a = seed[7:4];
      axw(REG_FLAGS, {28'h0, f}, RESP_OKAY);
      if (pass(j[3:0], f)) issue(j[3:0], CLS_BRANCH, 5'h1, 32'h0, 32'h4, 4'h2, a, 4'h0,
        ex(2, 1, 0, 0, 0, a));
      else issue(j[3:0], CLS_BRANCH, 5'h1, 32'h0, 32'h4, 4'h2, a, 4'h0,
        ex(1, 0, 0, 0, 15, f));
    end
    $display("test conditions done");
    axw(REG_FLAGS, 32'h2, RESP_OKAY);
    issue(CARRY_SET_ALIAS, CLS_DATA_PROC, 5'h1, 32'h0, 32'h0, 4'h0, 4'h9, 4'h0,
      ex(1, 0, 0, 0, 15, 4'h2));
    issue(CARRY_SET_ALIAS, CLS_DATA_PROC, 5'h1, 32'h0, 32'h0, 4'h4, 4'h9, 4'h0,
      ex(2, 0, 0, 0, 15, 4'h2));
    issue(CARRY_SET_ALIAS, CLS_DATA_PROC, 5'h1, 32'h0, 32'h0, 4'hc, 4'h9, 4'h0,
      ex(3, 1, 0, 0, 15, 4'h2));
    issue(EVERY_TIME_COND, CLS_WORD_LOAD, 5'h1, 32'h0, 32'h0, 4'h0, 4'h0, 4'h0,
      ex(1, 1, 1, 0, 15, 4'h2));
    issue(EVERY_TIME_COND, CLS_WORD_LOAD, 5'h1, 32'h0, 32'h0, 4'h8, 4'h0, 4'h0,
      ex(2, 2, 1, 0, 15, 4'h2));
    issue(EVERY_TIME_COND, CLS_WORD_STORE, 5'h1, 32'h0, 32'h0, 4'h0, 4'h0, 4'h0,
      ex(0, 2, 0, 0, 15, 4'h2));
    issue(EVERY_TIME_COND, CLS_MULTI_LOAD, 5'h5, 32'h0, 32'h0, 4'h0, 4'h0, 4'h0,
      ex(5, 1, 1, 0, 15, 4'h2));
    issue(EVERY_TIME_COND, CLS_MULTI_LOAD, 5'h5, 32'h0, 32'h0, 4'h8, 4'h0, 4'h0,
      ex(6, 2, 1, 0, 15, 4'h2));
    issue(EVERY_TIME_COND, CLS_MULTI_STORE, 5'h0, 32'h0, 32'h0, 4'h0, 4'h0, 4'h0,
      ex(0, 2, 0, 0, 15, 4'h2));
    issue(EVERY_TIME_COND, CLS_MULTI_STORE, 5'h10, 32'h0, 32'h0, 4'h0, 4'h0, 4'h0,
      ex(15, 2, 0, 0, 15, 4'h2));
    issue(EVERY_TIME_COND, CLS_COPROC_DATA_OP, 5'h1, 32'h0, 32'h0, 4'h0, 4'h0, 4'h2,
      ex(1, 0, 2, 0, 15, 4'h2));
    issue(EVERY_TIME_COND, CLS_COPROC_LOAD_STORE, 5'h3, 32'h0, 32'h0, 4'h0, 4'h0, 4'h0,
      ex(2, 2, 0, 0, 15, 4'h2));
    issue(EVERY_TIME_COND, CLS_COPROC_TO_CORE_MOVE, 5'h1, 32'h0, 32'h0, 4'h0, 4'h0, 4'h3,
      ex(1, 0, 3, 1, 15, 4'h2));
    issue(EVERY_TIME_COND, CLS_CORE_TO_COPROC_MOVE, 5'h1, 32'h0, 32'h0, 4'h0, 4'h0, 4'h0,
      ex(1, 0, 1, 1, 15, 4'h2));
    issue(NEVER_COND, CLS_COPROC_TO_CORE_MOVE, 5'h1, 32'h0, 32'h0, 4'h2, 4'h7, 4'h0,
      ex(1, 0, 0, 0, 15, 4'h2));
    issue(EVERY_TIME_COND, CLS_BRANCH, 5'h1, 32'h0, 32'hc, 4'h0, 4'h0, 4'h0,
      ex(2, 1, 0, 0, 1, 4'h2));
    issue(EVERY_TIME_COND, CLS_DATA_PROC, 5'h1, 32'h0, 32'h0, 4'h1, 4'h5, 4'h0,
      ex(1, 0, 0, 0, 15, 4'h5));
    $display("test timing done");
    for (int j = 0; j < 33; j++) begin
      seed = lfsr(seed);
      op = (j == 0) ? 32'h0 : ((32'h1 << (j - 1)) | (seed & ((32'h1 << (j - 1)) - 32'h1)));
      issue(EVERY_TIME_COND, CLS_PRODUCT, 5'h1, op, 32'h0, 4'h0, 4'h0, 4'h0,
        ex(1, 0, px(op), 0, 15, 4'h5));
    end
    $display("test product done");
    for (int k = 0; k < 100 && expq.size() != 0; k++) @(posedge clk_i);
    axr(REG_CYCLE_CNT, ncyc, RESP_OKAY);
    if (expq.size() != 0) n_fail++;
    results();
  end
endmodule : tb_cond_exec_cycle_timing
`default_nettype wire
